// [core/tir_pkg.sv]
// Function
// - Each period, load offset DAC from table
// - Each period, digitize temperature into index
// - Offset table: 176 words, one per refresh
// - Span table: 176 words, loaded into span DAC
// - Index = trunc(0.6561 * degC + 53.6)
// - Four trim DACs, 16 bits, full range
// - Setup word bit swaps bridge inputs
// - Setup field selects mirror ratio of four
// - Gain stage has 32 selectable steps
// - Drift words fixed, never refreshed from tables
// - User flash bytes never read as data
// - Index saturates between 0x00 and 0xaf
// - Offset table 0x000, span 0x200, index doubled
// - Word is low byte even, high odd
// - Entry loads setups and all DACs first
package tir_pkg;
	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int TICK_US           = 1000;
	localparam int TICK_CYCLES       = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int DEFAULT_PERIOD_MS = 4;
	localparam int PER_W             = 4;
	//////////////////////////////////////////////////////////////////////////////
	// Flash map
	localparam int          FA_W        = 11;
	localparam logic [10:0] OFF_BASE    = 11'h000;
	localparam logic [10:0] SPAN_BASE   = 11'h200;
	localparam logic [10:0] FA_SETUP1   = 11'h160;
	localparam logic [10:0] FA_SETUP2   = 11'h162;
	localparam logic [10:0] FA_OFS_DRF  = 11'h166;
	localparam logic [10:0] FA_SPN_DRF  = 11'h16a;
	localparam logic [10:0] USER0_LO    = 11'h180;
	localparam logic [10:0] USER0_HI    = 11'h1ff;
	localparam logic [10:0] USER1_LO    = 11'h380;
	localparam logic [10:0] USER1_HI    = 11'h3ff;
	localparam logic [7:0]  IDX_MIN     = 8'h00;
	localparam logic [7:0]  IDX_MAX     = 8'haf;
	localparam int          TABLE_WORDS = 176;
	// Index fit in Q16: 0.6561 and 53.6 scaled by 65536
	localparam logic signed [31:0] IDX_GAIN_Q16 = 32'sh0000a7f6;
	localparam logic signed [31:0] IDX_OFS_Q16  = 32'sh0035999a;
	localparam int                 IDX_FRAC     = 16;
	//////////////////////////////////////////////////////////////////////////////
	// Fetch slots
	localparam logic [2:0] SL_SETUP1  = 3'h0;
	localparam logic [2:0] SL_SETUP2  = 3'h1;
	localparam logic [2:0] SL_OFS_DRF = 3'h2;
	localparam logic [2:0] SL_SPN_DRF = 3'h3;
	localparam logic [2:0] SL_OFFSET  = 3'h4;
	localparam logic [2:0] SL_SPAN    = 3'h5;
	//////////////////////////////////////////////////////////////////////////////
	// Setup word fields
	localparam int SWAP_BIT = 0;
	localparam int MIR_LSB  = 1;
	localparam int MIR_W    = 2;
	localparam int GAIN_LSB = 3;
	localparam int GAIN_W   = 5;
	localparam int PER_LSB  = 0;
	//////////////////////////////////////////////////////////////////////////////
	// APB map
	localparam logic [7:0] RA_CTRL   = 8'h00;
	localparam logic [7:0] RA_STATUS = 8'h04;
	localparam logic [7:0] RA_SETUP1 = 8'h08;
	localparam logic [7:0] RA_SETUP2 = 8'h0c;
	localparam logic [7:0] RA_OFFSET = 8'h10;
	localparam logic [7:0] RA_SPAN   = 8'h14;
	localparam logic [7:0] RA_OFSDRF = 8'h18;
	localparam logic [7:0] RA_SPNDRF = 8'h1c;
	localparam int         ST_IDX_LSB = 8;
	localparam logic [15:0] WORD_RST  = 16'h0000;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_CONV = 5'b00010,
		S_REQ  = 5'b00100,
		S_WAIT = 5'b01000,
		S_RUN  = 5'b10000
	} tir_state_t;
endpackage : tir_pkg

// [core/tir_tick.sv]
`timescale 1ns/100ps
`default_nettype none
module tir_tick #(
	parameter int MS_CYCLES = tir_pkg::TICK_CYCLES
) (
	input  wire logic                     clk,       // Clock
	input  wire logic                     rst_n,     // Async reset
	input  wire logic                     en,        // Count while high
	input  wire logic [tir_pkg::PER_W-1:0] period_ms, // Zero means default
	output logic                          tick       // Period elapsed pulse
);
	localparam int CW = $clog2(MS_CYCLES + 1);

	logic [CW-1:0]             cyc_ff;
	logic [tir_pkg::PER_W-1:0] ms_ff;
	logic [tir_pkg::PER_W-1:0] target;
	logic                      ms_end;
	logic                      tick_ff;

	assign target = (period_ms == '0) ? tir_pkg::PER_W'(tir_pkg::DEFAULT_PERIOD_MS) : period_ms;
	assign ms_end = (cyc_ff == CW'(MS_CYCLES - 1));
	assign tick   = tick_ff;

	// Restart from zero whenever disabled so each period is whole
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_ff <= '0;
		end else if (!en || ms_end) begin
			cyc_ff <= '0;
		end else begin
			cyc_ff <= cyc_ff + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_ff   <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (!en) begin
				ms_ff <= '0;
			end else if (ms_end) begin
				if (ms_ff == target - tir_pkg::PER_W'(1)) begin
					ms_ff   <= '0;
					tick_ff <= 1'b1;
				end else begin
					ms_ff <= ms_ff + tir_pkg::PER_W'(1);
				end
			end
		end
	end
endmodule : tir_tick
`default_nettype wire

// [core/tir_top.sv]
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module tir_top #(
	parameter int MS_CYCLES = tir_pkg::TICK_CYCLES
) (
	input  wire logic                   clk,              // 100 MHz clock
	input  wire logic                   rst_n,            // Async reset
	input  wire logic [7:0]             paddr,            // APB address
	input  wire logic                   psel,             // APB select
	input  wire logic                   penable,          // APB enable
	input  wire logic                   pwrite,           // APB direction
	input  wire logic [31:0]            pwdata,           // APB write data
	output logic      [31:0]            prdata,           // APB read data
	output logic                        pready,           // APB ready
	output logic                        pslverr,          // APB error
	output logic      [tir_pkg::FA_W-1:0] flash_addr,     // Flash byte address
	output logic                        flash_rd,         // Flash read pulse
	input  wire logic [7:0]             flash_rdata,      // Flash byte
	input  wire logic                   flash_rvalid,     // Flash byte valid
	output logic                        adc_start,        // Start conversion
	input  wire logic                   adc_done,         // Conversion done
	input  wire logic signed [9:0]      adc_temp,         // Degrees C
	output logic      [7:0]             thermal_index,    // Saturated index
	output logic      [15:0]            offset_trim_dac,  // Offset DAC code
	output logic      [15:0]            span_trim_dac,    // Span DAC code
	output logic      [15:0]            offset_drift_dac, // Offset drift code
	output logic      [15:0]            span_drift_dac,   // Span drift code
	output logic                        input_swap,       // Swap bridge inputs
	output logic      [1:0]             mirror_ratio_sel, // Mirror ratio
	output logic      [4:0]             gain_stage        // Coarse gain step
);
	//////////////////////////////////////////////////////////////////////////////
	// Declarations
	tir_pkg::tir_state_t state_ff;
	tir_pkg::tir_state_t nxt_state;
	logic        run_ff;
	logic        run_d_ff;
	logic        full_ff;
	logic [2:0]  slot_ff;
	logic        hi_ff;
	logic [7:0]  lo_ff;
	logic [7:0]  idx_ff;
	logic        flash_rd_ff;
	logic [10:0] flash_addr_ff;
	logic        adc_start_ff;
	logic [15:0] setup1_ff;
	logic [15:0] setup2_ff;
	logic [15:0] offset_ff;
	logic [15:0] span_ff;
	logic [15:0] ofs_drf_ff;
	logic [15:0] spn_drf_ff;
	logic        swap_ff;
	logic [1:0]  mir_ff;
	logic [4:0]  gain_ff;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        tick;
	logic        commit;
	logic [15:0] word;
	logic        apb_wr;
	logic        sw_wr;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [7:0]  nxt_idx;

	//////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] temp_to_index(input logic signed [9:0] t);
		logic signed [31:0] acc;
		logic signed [31:0] whole;
		acc   = 32'(signed'({{22{t[9]}}, t})) * tir_pkg::IDX_GAIN_Q16 + tir_pkg::IDX_OFS_Q16;
		whole = acc >>> tir_pkg::IDX_FRAC;
		if (whole < 0) begin
			return tir_pkg::IDX_MIN;
		end else if (whole > 32'(tir_pkg::IDX_MAX)) begin
			return tir_pkg::IDX_MAX;
		end
		return whole[7:0];
	endfunction : temp_to_index

	// Even byte is low half, odd byte high half
	function automatic logic [10:0] slot_addr(input logic [2:0] s, input logic [7:0] ix, input logic hi);
		logic [10:0] base;
		base = tir_pkg::FA_SETUP1;
		unique case (s)
			tir_pkg::SL_SETUP1:  base = tir_pkg::FA_SETUP1;
			tir_pkg::SL_SETUP2:  base = tir_pkg::FA_SETUP2;
			tir_pkg::SL_OFS_DRF: base = tir_pkg::FA_OFS_DRF;
			tir_pkg::SL_SPN_DRF: base = tir_pkg::FA_SPN_DRF;
			tir_pkg::SL_OFFSET:  base = tir_pkg::OFF_BASE + {2'b00, ix, 1'b0};
			tir_pkg::SL_SPAN:    base = tir_pkg::SPAN_BASE + {2'b00, ix, 1'b0};
			default:             base = tir_pkg::FA_SETUP1;
		endcase
		return base | {10'h000, hi};
	endfunction : slot_addr

	assign nxt_idx = temp_to_index(adc_temp);
	assign word    = {flash_rdata, lo_ff};
	assign commit  = (state_ff == tir_pkg::S_WAIT) && flash_rvalid && hi_ff;

	//////////////////////////////////////////////////////////////////////////////
	// Refresh timer
	tir_tick #(
		.MS_CYCLES (MS_CYCLES)
	) u_tick (
		.clk       (clk),
		.rst_n     (rst_n),
		.en        (state_ff == tir_pkg::S_RUN),
		.period_ms (setup2_ff[tir_pkg::PER_LSB +: tir_pkg::PER_W]),
		.tick      (tick)
	);

	//////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			tir_pkg::S_IDLE: if (run_ff && !run_d_ff) nxt_state = tir_pkg::S_CONV;
			tir_pkg::S_CONV: if (adc_done) nxt_state = tir_pkg::S_REQ;
			tir_pkg::S_REQ:  nxt_state = tir_pkg::S_WAIT;
			tir_pkg::S_WAIT: begin
				if (flash_rvalid) begin
					nxt_state = (hi_ff && slot_ff == tir_pkg::SL_SPAN) ? tir_pkg::S_RUN : tir_pkg::S_REQ;
				end
			end
			tir_pkg::S_RUN:  if (tick) nxt_state = tir_pkg::S_CONV;
		endcase
		if (!run_ff) begin
			nxt_state = tir_pkg::S_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= tir_pkg::S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Full load only on entry; periodic refresh fetches the two tables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			full_ff <= 1'b0;
			slot_ff <= tir_pkg::SL_SETUP1;
			hi_ff   <= 1'b0;
			lo_ff   <= 8'h00;
		end else begin
			if (state_ff == tir_pkg::S_IDLE) begin
				full_ff <= 1'b1;
			end else if (state_ff == tir_pkg::S_RUN) begin
				full_ff <= 1'b0;
			end
			if (state_ff == tir_pkg::S_CONV && adc_done) begin
				slot_ff <= full_ff ? tir_pkg::SL_SETUP1 : tir_pkg::SL_OFFSET;
				hi_ff   <= 1'b0;
			end else if (state_ff == tir_pkg::S_WAIT && flash_rvalid) begin
				hi_ff <= !hi_ff;
				if (!hi_ff) begin
					lo_ff <= flash_rdata;
				end else if (slot_ff != tir_pkg::SL_SPAN) begin
					slot_ff <= slot_ff + 3'h1;
				end
			end
		end
	end

	// Index sampled once per refresh, shared by both table fetches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_ff       <= tir_pkg::IDX_MIN;
			adc_start_ff <= 1'b0;
		end else begin
			adc_start_ff <= (nxt_state == tir_pkg::S_CONV) && (state_ff != tir_pkg::S_CONV);
			if (state_ff == tir_pkg::S_CONV && adc_done) begin
				idx_ff <= nxt_idx;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flash_rd_ff   <= 1'b0;
			flash_addr_ff <= tir_pkg::OFF_BASE;
		end else begin
			flash_rd_ff <= (state_ff == tir_pkg::S_REQ) && run_ff;
			if (state_ff == tir_pkg::S_REQ) begin
				flash_addr_ff <= slot_addr(slot_ff, idx_ff, hi_ff);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Calibration words; software may write them only while stopped
	assign apb_wr = psel && penable && pready_ff && pwrite;
	assign sw_wr  = apb_wr && !run_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setup1_ff <= tir_pkg::WORD_RST;
			setup2_ff <= tir_pkg::WORD_RST;
		end else if (commit && slot_ff == tir_pkg::SL_SETUP1) begin
			setup1_ff <= word;
		end else if (commit && slot_ff == tir_pkg::SL_SETUP2) begin
			setup2_ff <= word;
		end else if (sw_wr && paddr == tir_pkg::RA_SETUP1) begin
			setup1_ff <= pwdata[15:0];
		end else if (sw_wr && paddr == tir_pkg::RA_SETUP2) begin
			setup2_ff <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_ff <= tir_pkg::WORD_RST;
			span_ff   <= tir_pkg::WORD_RST;
		end else if (commit && slot_ff == tir_pkg::SL_OFFSET) begin
			offset_ff <= word;
		end else if (commit && slot_ff == tir_pkg::SL_SPAN) begin
			span_ff <= word;
		end else if (sw_wr && paddr == tir_pkg::RA_OFFSET) begin
			offset_ff <= pwdata[15:0];
		end else if (sw_wr && paddr == tir_pkg::RA_SPAN) begin
			span_ff <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ofs_drf_ff <= tir_pkg::WORD_RST;
			spn_drf_ff <= tir_pkg::WORD_RST;
		end else if (commit && slot_ff == tir_pkg::SL_OFS_DRF) begin
			ofs_drf_ff <= word;
		end else if (commit && slot_ff == tir_pkg::SL_SPN_DRF) begin
			spn_drf_ff <= word;
		end else if (sw_wr && paddr == tir_pkg::RA_OFSDRF) begin
			ofs_drf_ff <= pwdata[15:0];
		end else if (sw_wr && paddr == tir_pkg::RA_SPNDRF) begin
			spn_drf_ff <= pwdata[15:0];
		end
	end

	// Analog selections registered from the first setup word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			swap_ff <= 1'b0;
			mir_ff  <= 2'h0;
			gain_ff <= 5'h00;
		end else begin
			swap_ff <= setup1_ff[tir_pkg::SWAP_BIT];
			mir_ff  <= setup1_ff[tir_pkg::MIR_LSB +: tir_pkg::MIR_W];
			gain_ff <= setup1_ff[tir_pkg::GAIN_LSB +: tir_pkg::GAIN_W];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// APB slave: ready in the second access cycle
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			tir_pkg::RA_CTRL:   rd_mux = {31'h0, run_ff};
			tir_pkg::RA_STATUS: rd_mux = {16'h0000, idx_ff, 3'h0, state_ff};
			tir_pkg::RA_SETUP1: rd_mux = {16'h0000, setup1_ff};
			tir_pkg::RA_SETUP2: rd_mux = {16'h0000, setup2_ff};
			tir_pkg::RA_OFFSET: rd_mux = {16'h0000, offset_ff};
			tir_pkg::RA_SPAN:   rd_mux = {16'h0000, span_ff};
			tir_pkg::RA_OFSDRF: rd_mux = {16'h0000, ofs_drf_ff};
			tir_pkg::RA_SPNDRF: rd_mux = {16'h0000, spn_drf_ff};
			default:            mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !mapped;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff   <= 1'b0;
			run_d_ff <= 1'b0;
		end else begin
			run_d_ff <= run_ff;
			if (apb_wr && paddr == tir_pkg::RA_CTRL) begin
				run_ff <= pwdata[0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign flash_addr       = flash_addr_ff;
	assign flash_rd         = flash_rd_ff;
	assign adc_start        = adc_start_ff;
	assign thermal_index    = idx_ff;
	assign offset_trim_dac  = offset_ff;
	assign span_trim_dac    = span_ff;
	assign offset_drift_dac = ofs_drf_ff;
	assign span_drift_dac   = spn_drf_ff;
	assign input_swap       = swap_ff;
	assign mirror_ratio_sel = mir_ff;
	assign gain_stage       = gain_ff;

	//////////////////////////////////////////////////////////////////////////////
	// Checks
	a_index_sat: assert property (@(posedge clk) disable iff (!rst_n)
		idx_ff <= tir_pkg::IDX_MAX) else $error("thermal index above ceiling");

	a_index_calc: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == tir_pkg::S_CONV && adc_done && run_ff) |=> idx_ff == $past(nxt_idx))
		else $error("thermal index not taken from conversion");

	a_no_user_read: assert property (@(posedge clk) disable iff (!rst_n)
		flash_rd_ff |-> !((flash_addr_ff >= tir_pkg::USER0_LO && flash_addr_ff <= tir_pkg::USER0_HI) ||
		(flash_addr_ff >= tir_pkg::USER1_LO && flash_addr_ff <= tir_pkg::USER1_HI)))
		else $error("user flash area read");

	a_offset_addr: assert property (@(posedge clk) disable iff (!rst_n)
		(flash_rd_ff && slot_ff == tir_pkg::SL_OFFSET) |->
		flash_addr_ff == (tir_pkg::OFF_BASE + {2'b00, idx_ff, hi_ff}))
		else $error("offset table address wrong");

	a_span_addr: assert property (@(posedge clk) disable iff (!rst_n)
		(flash_rd_ff && slot_ff == tir_pkg::SL_SPAN) |->
		flash_addr_ff == (tir_pkg::SPAN_BASE + {2'b00, idx_ff, hi_ff}))
		else $error("span table address wrong");

	a_dac_atomic: assert property (@(posedge clk) disable iff (!rst_n)
		(run_ff && !(commit && slot_ff == tir_pkg::SL_OFFSET)) |=> $stable(offset_ff))
		else $error("offset DAC changed without whole word");

	a_drift_fixed: assert property (@(posedge clk) disable iff (!rst_n)
		(commit && !full_ff) |-> (slot_ff == tir_pkg::SL_OFFSET || slot_ff == tir_pkg::SL_SPAN))
		else $error("drift word refreshed");

	a_refresh_starts: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == tir_pkg::S_RUN && tick && run_ff) |-> ##1 adc_start_ff)
		else $error("refresh did not start conversion");

	a_entry_full: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == tir_pkg::S_CONV && adc_done && full_ff && run_ff) |=> slot_ff == tir_pkg::SL_SETUP1)
		else $error("entry did not load setup words first");

	a_gain_follows: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> gain_ff == $past(setup1_ff[tir_pkg::GAIN_LSB +: tir_pkg::GAIN_W]))
		else $error("gain step not from setup word");
endmodule : tir_top
`default_nettype wire

// [dv/tir_flash_model.sv]
`timescale 1ns/100ps
`default_nettype none
module tir_flash_model (
	input  wire logic        clk,    // Clock
	input  wire logic        rst_n,  // Reset
	input  wire logic        slow,   // Long latency
	input  wire logic [10:0] addr,   // Byte address
	input  wire logic        rd,     // Read request
	output logic      [7:0]  rdata,  // Byte out
	output logic             rvalid, // Byte valid
	output var int           urd     // User-area reads
);
	logic        pend_ff;
	logic [10:0] a_ff;
	logic [2:0]  cnt_ff;
	function automatic logic [7:0] fb(input logic [10:0] a);
		return a[7:0] + 8'h35 * {5'h00, a[10:8]};
	endfunction : fb
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{pend_ff, a_ff, cnt_ff, rvalid, rdata} <= '0;
			urd <= 0;
		end else begin
			rvalid <= 1'b0;
			rdata  <= ~rdata; // Idle bus never repeats the last byte
			if (pend_ff && cnt_ff == 3'h0) begin
				rvalid  <= 1'b1;
				rdata   <= fb(a_ff);
				pend_ff <= 1'b0;
			end else if (pend_ff)
				cnt_ff <= cnt_ff - 3'h1;
			if (rd) begin
				pend_ff <= 1'b1;
				a_ff    <= addr;
				cnt_ff  <= slow ? 3'h4 : 3'h0;
				if ((addr >= tir_pkg::USER0_LO && addr <= tir_pkg::USER0_HI) ||
					(addr >= tir_pkg::USER1_LO && addr <= tir_pkg::USER1_HI))
					urd <= urd + 1;
			end
		end
	end
endmodule : tir_flash_model
`default_nettype wire

// [dv/tir_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tir_top_tb;
	localparam int MS = 20;
	logic               clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic               adc_done = 0, slow = 0, running = 0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0, d;
	logic signed [9:0]  adc_temp = 10'sh000, cur_temp = 10'sh019;
	logic [2:0]         acnt = 3'h0;
	logic [15:0]        pofs = 16'h0, pspn = 16'h0, ofs, spn, odr, sdr;
	logic [31:0]        prdata;
	logic [10:0]        fa;
	logic [7:0]         fd, idx;
	logic [4:0]         gain;
	logic [1:0]         mir;
	logic               pready, pslverr, frd, fv, astart, swp, e;
	int                 failures = 0, checks_done = 0, urd;
	tir_top #(.MS_CYCLES(MS)) uut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_addr(fa), .flash_rd(frd), .flash_rdata(fd), .flash_rvalid(fv),
		.adc_start(astart), .adc_done(adc_done), .adc_temp(adc_temp), .thermal_index(idx),
		.offset_trim_dac(ofs), .span_trim_dac(spn), .offset_drift_dac(odr), .span_drift_dac(sdr),
		.input_swap(swp), .mirror_ratio_sel(mir), .gain_stage(gain));
	tir_flash_model fm (.clk(clk), .rst_n(rst_n), .slow(slow), .addr(fa), .rd(frd), .rdata(fd),
		.rvalid(fv), .urd(urd));
	always #5 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] wd(input logic [10:0] a);
		return {a[7:0] + 8'h01 + 8'h35 * {5'h00, a[10:8]}, a[7:0] + 8'h35 * {5'h00, a[10:8]}};
	endfunction : wd
	function automatic logic [7:0] xi(input int t);
		int v;
		v = $rtoi($floor(0.6561 * t + 53.6));
		return (v < 0) ? 8'h00 : (v > 175) ? 8'haf : v[7:0];
	endfunction : xi
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wv);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wv};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		d = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		chk(pready, 1'b1);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(d, exp);
		chk(e, 1'b0);
	endtask : rdc
	// Converter answers a few cycles after each start
	always @(posedge clk) begin
		adc_done <= 1'b0;
		adc_temp <= ~adc_temp;
		if (astart)
			acnt <= 3'h3;
		else if (acnt == 3'h1) begin
			adc_done <= 1'b1;
			adc_temp <= cur_temp;
			acnt     <= 3'h0;
		end else if (acnt != 3'h0)
			acnt <= acnt - 3'h1;
	end
	// Any new trim word must be a whole entry of the current index
	always @(negedge clk) begin
		if (running && ofs !== pofs)
			chk(ofs, wd({2'b00, idx, 1'b0}));
		if (running && spn !== pspn)
			chk(spn, wd(11'h200 + {2'b00, idx, 1'b0}));
		pofs = ofs;
		pspn = spn;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_idle;
		rdc(tir_pkg::RA_STATUS, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk(d, 32'h0);
		chk(e, 1'b1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, tir_pkg::RA_SETUP1, {24'h0, 5'(i * 10 + 1), 2'(i), 1'(i)});
			repeat (2) @(posedge clk);
			chk({gain, mir, swp}, {5'(i * 10 + 1), 2'(i), 1'(i)});
		end
		apb(1'b1, tir_pkg::RA_OFSDRF, 32'hffff);
		rdc(tir_pkg::RA_OFSDRF, 32'hffff);
		chk(odr, 16'hffff);
	endtask : t_idle
	task automatic t_entry;
		apb(1'b1, tir_pkg::RA_CTRL, 32'h1);
		running = 1'b1;
		for (int n = 0; n < 100 && d[4:0] !== 5'h10; n++)
			apb(1'b0, tir_pkg::RA_STATUS, 32'h0);
		chk(d, {16'h0, xi(25), 8'h10});
		chk({ofs, spn}, {wd(11'h08c), wd(11'h28c)});
		chk({odr, sdr}, {wd(tir_pkg::FA_OFS_DRF), wd(tir_pkg::FA_SPN_DRF)});
		d = {16'h0, wd(tir_pkg::FA_SETUP1)};
		chk({gain, mir, swp}, d[7:0]);
	endtask : t_entry
	task automatic t_refresh(input int t, input logic s);
		int n;
		slow     <= s;
		cur_temp <= 10'(t);
		n = 0;
		while (spn !== wd(11'h200 + {2'b00, xi(t), 1'b0}) && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk(idx, xi(t));
		chk({ofs, spn}, {wd({2'b00, xi(t), 1'b0}), wd(11'h200 + {2'b00, xi(t), 1'b0})});
		chk({odr, sdr}, {wd(tir_pkg::FA_OFS_DRF), wd(tir_pkg::FA_SPN_DRF)});
	endtask : t_refresh
	task automatic t_stop;
		// Refused while running: the last refreshed entry stays
		apb(1'b1, tir_pkg::RA_OFFSET, 32'h1234);
		rdc(tir_pkg::RA_OFFSET, {16'h0, wd({2'b00, xi(185), 1'b0})});
		running = 1'b0;
		apb(1'b1, tir_pkg::RA_CTRL, 32'h0);
		apb(1'b0, tir_pkg::RA_STATUS, 32'h0);
		chk(d[4:0], 5'h01);
		apb(1'b1, tir_pkg::RA_OFFSET, 32'h1234);
		rdc(tir_pkg::RA_OFFSET, 32'h1234);
		chk(ofs, 16'h1234);
		chk(urd, 0);
	endtask : t_stop
	//////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_idle();
		t_entry();
		t_refresh(200, 1'b0);
		t_refresh(-100, 1'b1);
		t_refresh(185, 1'b0);
		t_stop();
		wrap_up();
	end
endmodule : tir_top_tb
`default_nettype wire
